// [design/tcc_pkg.sv]
// Package of constants and types for the timer capture and compare block.
// Function
// - Capture latches 16-bit count of selected time base.
// - Eight independent capture channels, own pin, buffer.
// - Falling mode captures every high-to-low edge.
// - Rising mode captures every low-to-high edge.
// - Both-edges mode captures every transition.
// - Prescaled modes capture every 4th/16th rising edge.
// - Each channel selects one of two timers.
// - Capture event wakes device in sleep or idle.
// - Four-entry first-in first-out capture buffer.
// - Interrupt once buffer holds one to four entries.
// - Only channels one and two request DMA.
// - Idle-stop bit 13 halts compare during idle.
// - Fault status bit 4 set by fault, hardware-cleared.
// - Timer select bit 3 picks second timer.
// - Modes 111/110 PWM; fault watched only in 111.
// - Mode 101 starts low, continuous pulses.
// - Mode 100 starts low, one pulse.
// - Mode 011 toggles pin each match.
// - Mode 010 starts high, match drives low.
// - Mode 001 starts low, match drives high.
// - Mode 000 disables the compare channel.
package tcc_pkg;
  localparam int          TCC_CHANNELS      = 8;
  localparam int          TCC_DEPTH         = 4;
  // Byte addresses on the register bus.
  localparam logic [7:0]  TCC_OFF_CMP_CTRL  = 8'h00;
  localparam logic [7:0]  TCC_OFF_CMP_PRI   = 8'h04;
  localparam logic [7:0]  TCC_OFF_CMP_SEC   = 8'h08;
  localparam logic [7:0]  TCC_OFF_CAP_CTRL  = 8'h20;
  localparam logic [7:0]  TCC_OFF_CAP_DATA  = 8'h40;
  // Compare control fields.
  localparam int          TCC_CC_IDLE_STOP  = 13;
  localparam int          TCC_CC_FAULT      = 4;
  localparam int          TCC_CC_TSEL       = 3;
  localparam int          TCC_CC_MODE_LSB   = 0;
  // Capture control fields.
  localparam int          TCC_CAP_MODE_LSB  = 0;
  localparam int          TCC_CAP_NEMPTY    = 3;
  localparam int          TCC_CAP_OVF       = 4;
  localparam int          TCC_CAP_FILL_LSB  = 5;
  localparam int          TCC_CAP_TSEL      = 7;
  // Reset values.
  localparam logic [15:0] TCC_RST_CMP_CTRL  = 16'h0000;
  localparam logic [15:0] TCC_RST_CMP_VAL   = 16'h0000;
  localparam logic [7:0]  TCC_RST_CAP_CTRL  = 8'h00;
  // Prescaler terminal counts.
  localparam logic [3:0]  TCC_PRE4_LAST     = 4'h3;
  localparam logic [3:0]  TCC_PRE16_LAST    = 4'hF;
  // Bus responses.
  localparam logic [1:0]  TCC_RESP_OKAY     = 2'b00;
  localparam logic [1:0]  TCC_RESP_SLVERR   = 2'b10;

  // Compare modes.
  typedef enum logic [2:0] {
    TCC_CMP_OFF    = 3'b000,
    TCC_CMP_SET    = 3'b001,
    TCC_CMP_CLR    = 3'b010,
    TCC_CMP_TOGGLE = 3'b011,
    TCC_CMP_SINGLE = 3'b100,
    TCC_CMP_CONT   = 3'b101,
    TCC_CMP_PWM    = 3'b110,
    TCC_CMP_PWMF   = 3'b111
  } tcc_cmp_mode_t;

  // Capture modes.
  typedef enum logic [2:0] {
    TCC_CAP_OFF   = 3'b000,
    TCC_CAP_BOTH  = 3'b001,
    TCC_CAP_FALL  = 3'b010,
    TCC_CAP_RISE  = 3'b011,
    TCC_CAP_PRE4  = 3'b100,
    TCC_CAP_PRE16 = 3'b101
  } tcc_cap_mode_t;

  // Pulse sequencer states, one-hot.
  typedef enum logic [2:0] {
    TCC_PS_WAIT = 3'b001,
    TCC_PS_HIGH = 3'b010,
    TCC_PS_DONE = 3'b100
  } tcc_pulse_t;
endpackage : tcc_pkg

// [design/tcc_top.sv]
// Timer capture channels and one compare channel behind an AXI4-Lite slave.
`timescale 1ns/100ps
`default_nettype none
module tcc_top
  import tcc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] time_base_first,
  input  wire logic [15:0] time_base_second,
  input  wire logic [7:0]  capture_input_pin,
  input  wire logic        cpu_sleep,
  input  wire logic        cpu_idle,
  input  wire logic        pwm_fault_in,
  output var  logic        compare_output_pin,
  output var  logic [7:0]  capture_irq,
  output var  logic [1:0]  capture_dma_req,
  output var  logic        wake_req
);

  // Picks one of the two time bases; shared by capture and compare.
  function automatic logic [15:0] pick_base(input logic sel, input logic [15:0] a,
                                            input logic [15:0] b);
    pick_base = sel ? b : a;
  endfunction : pick_base

  // Merges write data into a 16-bit register under the byte strobes.
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? d[15:8] : old[15:8], strb[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // Write holding registers; address and data may come in either order.
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_go;
  logic        wr_hit;
  logic        rd_hit;
  logic [31:0] next_rdata;

  // Compare channel registers.
  logic [15:0] cmp_ctrl;     // Control word, fault bit is driven by hardware.
  logic [15:0] cmp_pri;      // Primary match value.
  logic [15:0] cmp_sec;      // Secondary match value, pulse end.
  logic        cmp_ctrl_wr;  // Control written this cycle.
  logic [7:0]  cap_ctrl [TCC_CHANNELS]; // Capture control per channel.

  // Capture state.
  logic [7:0]  sync1;
  logic [7:0]  sync2;
  logic [7:0]  pin_prev;
  logic [3:0]  pre_cnt [TCC_CHANNELS];
  logic [7:0]  cap_evt;
  logic [15:0] fifo [TCC_CHANNELS][TCC_DEPTH];
  logic [1:0]  rd_ptr [TCC_CHANNELS];
  logic [2:0]  fill [TCC_CHANNELS];
  logic [7:0]  ovf;
  logic [7:0]  pop;
  logic [7:0]  push;
  logic        next_fault;

  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  // Write address and data capture; each ready drops once its item is held.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      // Ready is offered one cycle ahead so the handshake stays registered.
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_go)
      begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_go)
      begin
        w_held <= 1'b0;
      end
    end
  end

  // Write decode: unmapped offsets answer with a slave error.
  always_comb
  begin
    wr_hit = (aw_addr == TCC_OFF_CMP_CTRL) || (aw_addr == TCC_OFF_CMP_PRI) ||
             (aw_addr == TCC_OFF_CMP_SEC) ||
             ((aw_addr[7:5] == TCC_OFF_CAP_CTRL[7:5]) && (aw_addr[1:0] == 2'b00));
  end

  // Write response follows both halves of the write.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= TCC_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? TCC_RESP_OKAY : TCC_RESP_SLVERR;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  assign cmp_ctrl_wr = wr_go && (aw_addr == TCC_OFF_CMP_CTRL);

  // Compare registers; the fault status bit is not writable by software.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cmp_ctrl <= TCC_RST_CMP_CTRL;
      cmp_pri  <= TCC_RST_CMP_VAL;
      cmp_sec  <= TCC_RST_CMP_VAL;
    end
    else
    begin
      if (cmp_ctrl_wr)
      begin
        // Only idle-stop, timer select and mode are writable.
        cmp_ctrl[TCC_CC_IDLE_STOP]        <= w_strb[1] ? w_data[TCC_CC_IDLE_STOP]
                                                       : cmp_ctrl[TCC_CC_IDLE_STOP];
        cmp_ctrl[TCC_CC_TSEL]             <= w_strb[0] ? w_data[TCC_CC_TSEL]
                                                       : cmp_ctrl[TCC_CC_TSEL];
        cmp_ctrl[TCC_CC_MODE_LSB +: 3]    <= w_strb[0] ? w_data[TCC_CC_MODE_LSB +: 3]
                                                       : cmp_ctrl[TCC_CC_MODE_LSB +: 3];
      end
      if (wr_go && (aw_addr == TCC_OFF_CMP_PRI))
      begin
        cmp_pri <= merge16(cmp_pri, w_data, w_strb);
      end
      if (wr_go && (aw_addr == TCC_OFF_CMP_SEC))
      begin
        cmp_sec <= merge16(cmp_sec, w_data, w_strb);
      end
      cmp_ctrl[TCC_CC_FAULT] <= next_fault;
    end
  end

  // Capture control registers, one byte each.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < TCC_CHANNELS; i++)
      begin
        cap_ctrl[i] <= TCC_RST_CAP_CTRL;
      end
    end
    else if (wr_go && (aw_addr[7:5] == TCC_OFF_CAP_CTRL[7:5]) && w_strb[0])
    begin
      cap_ctrl[aw_addr[4:2]] <= w_data[7:0];
    end
  end

  // Read decode; the status bits of capture control show the buffer state.
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    rd_hit     = 1'b1;
    if (s_axi_araddr == TCC_OFF_CMP_CTRL)
    begin
      next_rdata[15:0] = cmp_ctrl;
    end
    else if (s_axi_araddr == TCC_OFF_CMP_PRI)
    begin
      next_rdata[15:0] = cmp_pri;
    end
    else if (s_axi_araddr == TCC_OFF_CMP_SEC)
    begin
      next_rdata[15:0] = cmp_sec;
    end
    else if ((s_axi_araddr[7:5] == TCC_OFF_CAP_CTRL[7:5]) && (s_axi_araddr[1:0] == 2'b00))
    begin
      next_rdata[7:0]                = cap_ctrl[s_axi_araddr[4:2]];
      next_rdata[TCC_CAP_NEMPTY]     = (fill[s_axi_araddr[4:2]] != 3'd0);
      next_rdata[TCC_CAP_OVF]        = ovf[s_axi_araddr[4:2]];
    end
    else if ((s_axi_araddr[7:5] == TCC_OFF_CAP_DATA[7:5]) && (s_axi_araddr[1:0] == 2'b00))
    begin
      // Reading the data word pops the oldest entry; an empty buffer reads zero.
      if (fill[s_axi_araddr[4:2]] != 3'd0)
      begin
        next_rdata[15:0] = fifo[s_axi_araddr[4:2]][rd_ptr[s_axi_araddr[4:2]]];
      end
    end
    else
    begin
      rd_hit = 1'b0;
    end
  end

  // Pop strobes: one read of a data word removes one entry.
  always_comb
  begin
    pop = 8'h00;
    if (s_axi_arvalid && s_axi_arready &&
        (s_axi_araddr[7:5] == TCC_OFF_CAP_DATA[7:5]) && (s_axi_araddr[1:0] == 2'b00))
    begin
      pop[s_axi_araddr[4:2]] = (fill[s_axi_araddr[4:2]] != 3'd0);
    end
  end

  // A full buffer takes a sample only while one leaves.
  always_comb
  begin
    for (int i = 0; i < TCC_CHANNELS; i++)
    begin
      push[i] = cap_evt[i] && ((fill[i] != 3'd4) || pop[i]);
    end
  end

  // Read channel: one read at a time, answered the next cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= TCC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= next_rdata;
        s_axi_rresp  <= rd_hit ? TCC_RESP_OKAY : TCC_RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Two-stage synchroniser and edge memory for the capture pins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1    <= 8'h00;
      sync2    <= 8'h00;
      pin_prev <= 8'h00;
    end
    else
    begin
      sync1    <= capture_input_pin;
      sync2    <= sync1;
      pin_prev <= sync2;
    end
  end

  // Edge qualification per channel; prescaler counts rising edges only.
  always_comb
  begin
    for (int i = 0; i < TCC_CHANNELS; i++)
    begin
      unique case (tcc_cap_mode_t'(cap_ctrl[i][TCC_CAP_MODE_LSB +: 3]))
        TCC_CAP_BOTH:  cap_evt[i] = sync2[i] ^ pin_prev[i];
        TCC_CAP_FALL:  cap_evt[i] = !sync2[i] && pin_prev[i];
        TCC_CAP_RISE:  cap_evt[i] = sync2[i] && !pin_prev[i];
        TCC_CAP_PRE4:  cap_evt[i] = sync2[i] && !pin_prev[i] &&
                                    (pre_cnt[i] == TCC_PRE4_LAST);
        TCC_CAP_PRE16: cap_evt[i] = sync2[i] && !pin_prev[i] &&
                                    (pre_cnt[i] == TCC_PRE16_LAST);
        default:       cap_evt[i] = 1'b0;
      endcase
    end
  end

  // Prescaler counters restart whenever bit 2 of the capture mode is clear.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < TCC_CHANNELS; i++)
      begin
        pre_cnt[i] <= 4'h0;
      end
    end
    else
    begin
      for (int i = 0; i < TCC_CHANNELS; i++)
      begin
        if (cap_ctrl[i][2] == 1'b0)
        begin
          pre_cnt[i] <= 4'h0;
        end
        else if (sync2[i] && !pin_prev[i])
        begin
          pre_cnt[i] <= cap_evt[i] ? 4'h0 : pre_cnt[i] + 4'h1;
        end
      end
    end
  end

  // Per-channel four-entry buffers. A full buffer with no read in the same cycle drops the new value and
  // flags overflow, keeping the oldest samples intact for software.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < TCC_CHANNELS; i++)
      begin
        rd_ptr[i] <= 2'd0;
        fill[i]   <= 3'd0;
        for (int j = 0; j < TCC_DEPTH; j++)
        begin
          fifo[i][j] <= 16'h0000;
        end
      end
      ovf <= 8'h00;
    end
    else
    begin
      for (int i = 0; i < TCC_CHANNELS; i++)
      begin
        if (push[i])
        begin
          fifo[i][2'(rd_ptr[i] + fill[i][1:0])] <= pick_base(cap_ctrl[i][TCC_CAP_TSEL],
              time_base_first, time_base_second);
        end
        if (pop[i])
        begin
          rd_ptr[i] <= rd_ptr[i] + 2'd1;
        end
        fill[i] <= fill[i] + {2'b00, push[i]} - {2'b00, pop[i]};
        // Overflow is sticky until the buffer is emptied; a new drop wins.
        if (cap_evt[i] && !push[i])
        begin
          ovf[i] <= 1'b1;
        end
        else if (fill[i] == 3'd0)
        begin
          ovf[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt, DMA request and wake-up outputs, all registered.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      capture_irq     <= 8'h00;
      capture_dma_req <= 2'b00;
      wake_req        <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < TCC_CHANNELS; i++)
      begin
        // Fill level code n raises the line at n+1 entries.
        capture_irq[i] <= (fill[i] > {1'b0, cap_ctrl[i][TCC_CAP_FILL_LSB +: 2]});
      end
      // Only the first two channels have DMA; software keeps their fill code 0.
      capture_dma_req[0] <= (fill[0] > {1'b0, cap_ctrl[0][TCC_CAP_FILL_LSB +: 2]});
      capture_dma_req[1] <= (fill[1] > {1'b0, cap_ctrl[1][TCC_CAP_FILL_LSB +: 2]});
      wake_req <= (|cap_evt) && (cpu_sleep || cpu_idle);
    end
  end

  // Compare channel working signals.
  tcc_cmp_mode_t cmp_mode;
  tcc_pulse_t    pulse_st;
  tcc_pulse_t    next_pulse_st;
  logic [15:0]   cmp_base;
  logic          cmp_run;
  logic          hit_pri;
  logic          hit_sec;

  assign cmp_mode = tcc_cmp_mode_t'(cmp_ctrl[TCC_CC_MODE_LSB +: 3]);
  assign cmp_base = pick_base(cmp_ctrl[TCC_CC_TSEL], time_base_first,
                              time_base_second);
  // Idle stop freezes the matches; the pin holds its level unless a mode 111 fault forces it low.
  assign cmp_run  = !(cpu_idle && cmp_ctrl[TCC_CC_IDLE_STOP]);
  assign hit_pri  = cmp_run && (cmp_base == cmp_pri);
  assign hit_sec  = cmp_run && (cmp_base == cmp_sec);

  // Fault sets while watched; hardware clears it at a period start once the input is gone.
  always_comb
  begin
    next_fault = cmp_ctrl[TCC_CC_FAULT];
    if (cmp_mode != TCC_CMP_PWMF)
    begin
      next_fault = 1'b0;
    end
    else if (pwm_fault_in)
    begin
      next_fault = 1'b1;
    end
    else if (cmp_run && (cmp_base == 16'h0000))
    begin
      next_fault = 1'b0;
    end
  end

  // Pulse sequencer for modes 100 and 101.
  always_comb
  begin
    next_pulse_st = pulse_st;
    unique case (pulse_st)
      TCC_PS_WAIT: if (hit_pri) next_pulse_st = TCC_PS_HIGH;
      TCC_PS_HIGH: if (hit_sec)
                     next_pulse_st = (cmp_mode == TCC_CMP_SINGLE) ? TCC_PS_DONE
                                                                  : TCC_PS_WAIT;
      TCC_PS_DONE: next_pulse_st = TCC_PS_DONE;
      default:     next_pulse_st = TCC_PS_WAIT;
    endcase
  end

  // Pulse state restarts on every write of the control word.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || cmp_ctrl_wr)
    begin
      pulse_st <= TCC_PS_WAIT;
    end
    else
    begin
      pulse_st <= next_pulse_st;
    end
  end

  // Compare pin; a control write initialises it for the new mode.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      compare_output_pin <= 1'b0;
    end
    else if (cmp_ctrl_wr)
    begin
      compare_output_pin <= w_strb[0] &&
                            (w_data[TCC_CC_MODE_LSB +: 3] == TCC_CMP_CLR);
    end
    else
    begin
      unique case (cmp_mode)
        TCC_CMP_OFF:    compare_output_pin <= 1'b0;
        TCC_CMP_SET:    if (hit_pri) compare_output_pin <= 1'b1;
        TCC_CMP_CLR:    if (hit_pri) compare_output_pin <= 1'b0;
        TCC_CMP_TOGGLE: if (hit_pri) compare_output_pin <= !compare_output_pin;
        TCC_CMP_SINGLE,
        TCC_CMP_CONT:   compare_output_pin <= (next_pulse_st == TCC_PS_HIGH);
        TCC_CMP_PWM,
        TCC_CMP_PWMF:
        begin
          // Period starts at base zero, duty ends at the primary match.
          if (next_fault)
          begin
            compare_output_pin <= 1'b0;
          end
          else if (hit_pri)
          begin
            compare_output_pin <= 1'b0;
          end
          else if (cmp_run && (cmp_base == 16'h0000))
          begin
            compare_output_pin <= 1'b1;
          end
        end
      endcase
    end
  end

endmodule : tcc_top
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the block.
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import tcc_pkg::*;
;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0;
  logic awr, wr_r, bv, arr, rv, pin, wake, sleep = 0, idle = 0, sel = 0, on = 0, flt;
  logic [7:0] awa = 8'h00, ara = 8'h00, irq, cpin;
  logic [31:0] wd = 32'h0000_0000, rdat;
  logic [1:0] bresp, rresp, dma;
  logic [15:0] t1 = 16'h0000, t2 = 16'h0000, i1 = 16'h00FF, i2 = 16'h00FF, seed = 16'h0007;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int n_mismatch = 0, cmp_count = 0, cyc = 0, step = 40, highs = 0, wakes = 0;
  tcc_cap_mode_t cmod[6] = '{TCC_CAP_BOTH, TCC_CAP_FALL, TCC_CAP_RISE, TCC_CAP_PRE4,
                             TCC_CAP_PRE16, TCC_CAP_RISE};
  int np[6] = '{2, 3, 5, 8, 16, 2};  // Pulses per channel.
  int fl[6] = '{0, 0, 3, 1, 2, 2};   // Fill codes; DMA channels keep 0
  int kc[6] = '{4, 3, 5, 2, 1, 2};   // Capture events, including any beyond the 4-entry buffer.
  logic [15:0] ctl[10] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005,
                           16'h000E, 16'h0007, 16'h2003, 16'h0003};
  int hi[10] = '{0, 34, 6, 20, 3, 6, 10, 0, 0, 20};  // High samples.
  tcc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .time_base_first(t1),
    .time_base_second(t2), .capture_input_pin(cpin), .cpu_sleep(sleep), .cpu_idle(idle),
    .pwm_fault_in(flt), .compare_output_pin(pin), .capture_irq(irq),
    .capture_dma_req(dma), .wake_req(wake));
  tcc_pin_model u_pin (.aclk(aclk), .compare_output_pin(pin), .capture_input_pin(cpin),
    .pwm_fault_in(flt));
  always #25 aclk = ~aclk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while ((awv && !awr) || (wv && !wr_r));
    brdy <= 1'b1;
    do @(posedge aclk); while (!bv);
    brdy <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    ara <= a;
    arv <= 1'b1;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    rrdy <= 1'b1;
    do @(posedge aclk); while (!rv);
    rrdy <= 1'b0;
  endtask : rd
  // Time bases ramp 0..19 on the selected timer in a pass.
  always @(posedge aclk)
  begin
    if (on && pin === 1'b1) highs <= highs + 1;
    if (wake === 1'b1) wakes <= wakes + 1;
    on <= (step < 40);
    t1 <= (step < 40) ? (sel ? 16'h0000 : 16'(step % 20)) : i1;
    t2 <= (step < 40) ? (sel ? 16'(step % 20) : 16'h0000) : i2;
    if (step < 40) step <= step + 1;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  // Answers meet the oldest note.
  always @(posedge aclk)
  begin
    if (rv && rrdy) chk({rresp, rdat}, rq.pop_front());
    if (bv && brdy) chk(34'(bresp), 34'(bq.pop_front()));
  end
  task automatic cap(input int c);
    logic [15:0] s1, s2;
    logic [31:0] cfg;
    int k;
    s1 = lfsr(seed);
    s2 = lfsr(s1);
    seed = s2;
    i1 <= s1;
    i2 <= s2;
    sleep <= (c == 0);
    idle <= (c == 1);
    k = (kc[c] > 4) ? 4 : kc[c];
    cfg = 32'(cmod[c]) | (32'(fl[c]) << 5) | (32'(c % 2) << 7);
    wr(TCC_OFF_CAP_CTRL + 8'(4 * c), cfg, TCC_RESP_OKAY);
    repeat (np[c]) u_pin.pulse(c);
    repeat (4) @(posedge aclk);
    chk(34'(irq[c]), 34'(k > fl[c]));
    rd(TCC_OFF_CAP_CTRL + 8'(4 * c), 34'(cfg | (k > 0 ? 8 : 0) | (kc[c] > 4 ? 16 : 0)));
    repeat (k) rd(TCC_OFF_CAP_DATA + 8'(4 * c), 34'(c[0] ? s2 : s1));
    rd(TCC_OFF_CAP_DATA + 8'(4 * c), 34'h0);
    repeat (2) @(posedge aclk);
    chk(34'(irq[c]), 34'h0);
  endtask : cap
  task automatic cmp(input int r);
    idle <= (r > 7);
    sel <= ctl[r][3];
    u_pin.set_fault(ctl[r][2:0] > 3'h5);
    wr(TCC_OFF_CMP_CTRL, 32'(ctl[r]), TCC_RESP_OKAY);
    repeat (3) @(posedge aclk);
    highs = 0;
    step <= 0;
    repeat (44) @(posedge aclk);
    chk(34'(highs), 34'(hi[r]));
    rd(TCC_OFF_CMP_CTRL, 34'(ctl[r] | (ctl[r][2:0] == 3'h7 ? 16'h0010 : 16'h0000)));
  endtask : cmp
  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(TCC_OFF_CMP_CTRL, 34'h0);
    rd(8'h60, {TCC_RESP_SLVERR, 32'h0000_0000});
    wr(8'h60, 32'h0000_0001, TCC_RESP_SLVERR);
    for (int i = 0; i < 6; i++) cap(i);
    chk(34'(wakes), 34'd7);
    i1 <= 16'h00FF;
    i2 <= 16'h00FF;
    wr(TCC_OFF_CMP_PRI, 32'h0000_0005, TCC_RESP_OKAY);
    wr(TCC_OFF_CMP_SEC, 32'h0000_0008, TCC_RESP_OKAY);
    for (int i = 0; i < 10; i++) cmp(i);
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire

// [tb/tcc_chk.sv]
// Port-level checker for the block.
`timescale 1ns/100ps
`default_nettype none
module tcc_chk
  import tcc_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        cpu_sleep,
  input wire logic        cpu_idle,
  input wire logic        pwm_fault_in,
  input wire logic        compare_output_pin,
  input wire logic [7:0]  capture_irq,
  input wire logic [1:0]  capture_dma_req,
  input wire logic        wake_req
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic       wr_go;  // Both write halves taken.
  logic [2:0] cmode;  // Compare mode last written.
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // Assumes both write channels are taken at one edge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cmode <= 3'h0;
    else if (wr_go && s_axi_awaddr == TCC_OFF_CMP_CTRL)
      cmode <= s_axi_wdata[2:0];
  end
  AST_RST_OUT: assert property ($rose(aresetn) |-> !compare_output_pin && capture_irq == 8'h00)
    else $error("outputs not reset");
  AST_DMA: assert property (capture_dma_req == capture_irq[1:0])
    else $error("dma request differs");
  AST_WAKE: assert property (wake_req |->
    $past(cpu_sleep) || $past(cpu_idle) || $past(cpu_sleep, 2) || $past(cpu_idle, 2))
    else $error("wake while running");
  AST_OFF: assert property (cmode == 3'h0 [*3] |-> !compare_output_pin)
    else $error("disabled compare drives pin");
  AST_FAULT: assert property (cmode == 3'h7 && pwm_fault_in [*3] |-> !compare_output_pin)
    else $error("fault left pin high");
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_BTIME: assert property (wr_go |-> ##2 s_axi_bvalid)
    else $error("write response late");
  AST_RERR: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h60 |=>
    s_axi_rvalid && s_axi_rresp == TCC_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule : tcc_chk
bind tcc_top tcc_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle), .pwm_fault_in(pwm_fault_in),
  .compare_output_pin(compare_output_pin), .capture_irq(capture_irq),
  .capture_dma_req(capture_dma_req), .wake_req(wake_req));
`default_nettype wire

// [tb/tcc_pin_model.sv]
// Far-side model: capture and fault pin source, compare pin load.
`timescale 1ns/100ps
`default_nettype none
module tcc_pin_model
(
  input  wire logic       aclk,
  input  wire logic       compare_output_pin,
  output var  logic [7:0] capture_input_pin,
  output var  logic       pwm_fault_in
);
  // Pins rest low, so the first rise is a real edge.
  initial
  begin
    capture_input_pin = 8'h00;
    pwm_fault_in = 1'b0;
  end
  // One pulse, long enough for the synchroniser.
  task automatic pulse(input int c);
    capture_input_pin[c] <= 1'b1;
    repeat (4) @(posedge aclk);
    capture_input_pin[c] <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask : pulse
  task automatic set_fault(input logic v);
    pwm_fault_in <= v;
  endtask : set_fault
endmodule : tcc_pin_model
`default_nettype wire
